// [core/rmc_pkg.sv]
// Package: shared constants and types of the receiver mode controller
package rmc_pkg;
  // ===========================================================
  // Register map (byte addresses over classic Wishbone)
  localparam logic [7:0] RMC_MAIN_MODE_ADDR   = 8'h00; // main_mode_control_reg
  localparam logic [7:0] RMC_CHAN_CFG_ADDR    = 8'h04; // channel_config_reg A..D
  localparam logic [7:0] RMC_POLL_CFG_ADDR    = 8'h08;
  localparam logic [7:0] RMC_STATUS_ADDR      = 8'h0c;
  localparam logic [7:0] RMC_ACC_CHAN_ADDR    = 8'h10; // accepted_channel_status_reg
  localparam logic [7:0] RMC_EVENT_ADDR       = 8'h14; // read-clear event flags
  // main_mode_control_reg fields
  localparam int MM_MODE_SEL   = 0; // mode_select_bit
  localparam int MM_SLAVE_RX   = 1; // slave_receive_enable
  localparam int MM_HOLD       = 2;
  localparam int MM_PLL_RECAL  = 3; // pll_recal_on_hold_release
  localparam int MM_CFG_LO     = 4; // config_select_field [5:4]
  localparam int MM_TRANSP     = 6;
  localparam int MM_MOD_TYPE   = 7; // modulation_type_bit
  // Poll config: [1:0] last configuration, [15:8] off_time cycles
  localparam int PC_OFF_LO     = 8;
  // ===========================================================
  // Timing
  localparam int CLK_MHZ          = 25;
  localparam int STARTUP_US       = 20;
  localparam int CHAN_HOP_US      = 10;
  localparam int INIT_CYC         = 4;
  localparam int SCAN_CYC         = 16;
  localparam int STARTUP_CYC      = STARTUP_US * CLK_MHZ;
  localparam int CHAN_HOP_CYC     = CHAN_HOP_US * CLK_MHZ;
  localparam logic [1:0] RMC_CFG_A = 2'h0;
  localparam logic [1:0] RMC_CH_1  = 2'h1;
  localparam logic [1:0] RMC_CH_3  = 2'h3;

  typedef enum logic [8:0] {
    ST_SLEEP   = 9'h001,
    ST_STARTUP = 9'h002,
    ST_HOPWAIT = 9'h004,
    ST_INIT    = 9'h008,
    ST_RUN     = 9'h010, // run mode slave operating states
    ST_HOLD    = 9'h020,
    ST_SCAN    = 9'h040, // self polling on-time
    ST_OFF     = 9'h080, // self polling off_time
    ST_RUN_MODE_SELF_POLLING    = 9'h100  // run_mode_self_polling
  } rmc_state_t;
endpackage

// [core/rmc_if.sv]
// Interface: link between the receiver core and its host-side controller
`timescale 1ns/1ns
`default_nettype none
interface rmc_if;
  logic [7:0]  main_mode;      // main_mode_control_reg
  logic [7:0]  chan_cfg;       // channel_config_reg, 2 bits per config
  logic [15:0] poll_cfg;
  logic [8:0]  state;
  logic [1:0]  acc_chan;       // accepted_channel_status_reg
  logic [1:0]  acc_cfg;
  logic        frame_start;    // frame_sync_word found, pulse
  logic        id_match;       // message_identifier matched, pulse
  logic        msg_end;        // end_of_message, pulse
  logic        wake_event;     // wake-up criterion met, pulse
  logic        mod_active;     // modulation in use
  logic        transp;         // raw stream to application controller
  modport dev  (input main_mode, chan_cfg, poll_cfg,
                output state, acc_chan, acc_cfg, frame_start, id_match,
                msg_end, wake_event, mod_active, transp);
  modport host (output main_mode, chan_cfg, poll_cfg,
                input state, acc_chan, acc_cfg, frame_start, id_match,
                msg_end, wake_event, mod_active, transp);
endinterface
`default_nettype wire

// [core/rmc_device.sv]
// Device end: master control state machine of the receiver
// ===========================================================
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module rmc_device
  import rmc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  rmc_if.dev              link,
  input  wire logic       rf_preamble,   // preamble_sequence seen
  input  wire logic       rf_sync,       // frame_sync_word seen
  input  wire logic       rf_id_ok,      // message_identifier matched
  input  wire logic       rf_eom,        // end_of_message
  input  wire logic       rf_wake,       // wake-up criterion met
  input  wire logic       rf_timeout,    // any self polling timeout
  input  wire logic       eom_return,    // return to polling on end
  input  wire logic [7:0] rf_byte,
  input  wire logic       rf_byte_vld,
  output logic            rf_power,
  output logic            osc_low_power,
  output logic            vco_cal_start, // vco_auto_calibration
  output logic [1:0]      active_cfg,
  output logic [1:0]      active_chan,
  output logic [7:0]      fifo_data,
  output logic            fifo_wr
);
  // ===========================================================
  // Input synchronisers for pins
  logic [7:0] sync1_reg, sync2_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {rf_preamble, rf_sync, rf_id_ok, rf_eom, rf_wake,
                    rf_timeout, eom_return, rf_byte_vld};
      sync2_reg <= sync1_reg;
    end
  end
  logic pre_s, sync_s, id_s, eom_s, wake_s, to_s, ret_s, bvld_s;
  assign {pre_s, sync_s, id_s, eom_s, wake_s, to_s, ret_s, bvld_s} =
    sync2_reg;
  logic [7:0] byte1_reg, byte2_reg;
  always_ff @(posedge clk) begin
    byte1_reg <= rf_byte;
    byte2_reg <= byte1_reg;
  end

  // ===========================================================
  // Mode decode
  logic       mode_select_bit, slrx, hold, recal;
  logic [1:0] cfg_sel, last_cfg;
  logic [7:0] off_len;
  assign mode_select_bit     = link.main_mode[MM_MODE_SEL];
  assign slrx     = link.main_mode[MM_SLAVE_RX];
  assign hold     = link.main_mode[MM_HOLD];
  assign recal    = link.main_mode[MM_PLL_RECAL];
  assign cfg_sel  = link.main_mode[MM_CFG_LO +: 2];
  assign last_cfg = link.poll_cfg[1:0];
  assign off_len  = link.poll_cfg[PC_OFF_LO +: 8];

  // ===========================================================
  // State machine
  rmc_state_t state_reg;
  logic [15:0] cnt_reg;
  logic        pre_seen_reg, in_frame_reg;
  logic [1:0]  cfg_reg, chan_reg;

  function automatic logic [1:0] chan_of(input logic [7:0] cc,
                                         input logic [1:0] c);
    logic [1:0] v;
    v = cc[{c, 1'b0} +: 2];
    chan_of = (v == 2'h0) ? RMC_CH_1 : v;
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_SLEEP;
      cnt_reg   <= '0;
      cfg_reg   <= RMC_CFG_A;
      chan_reg  <= RMC_CH_1;
    end else begin
      cnt_reg <= cnt_reg + 16'h1;
      unique case (state_reg)
        ST_SLEEP: begin
          cnt_reg <= '0;
          if (mode_select_bit || slrx) begin
            state_reg <= ST_STARTUP;
            cfg_reg   <= mode_select_bit ? RMC_CFG_A : cfg_sel;
            // Polling walks up from channel 1; slave uses the chosen one
            chan_reg  <= mode_select_bit ? RMC_CH_1 :
                         chan_of(link.chan_cfg, cfg_sel);
          end
        end
        ST_STARTUP: if (cnt_reg >= 16'(STARTUP_CYC - 1)) begin
          state_reg <= ST_INIT;
          cnt_reg   <= '0;
        end
        ST_HOPWAIT: if (cnt_reg >= 16'(CHAN_HOP_CYC - 1)) begin
          state_reg <= ST_INIT;
          cnt_reg   <= '0;
        end
        ST_INIT: if (cnt_reg >= 16'(INIT_CYC - 1)) begin
          state_reg <= mode_select_bit ? ST_SCAN : ST_RUN;
          cnt_reg   <= '0;
        end
        ST_RUN: begin
          if (!slrx || mode_select_bit) state_reg <= ST_SLEEP;
          else if (hold) state_reg <= ST_HOLD;
        end
        ST_HOLD: begin
          cnt_reg <= '0;
          cfg_reg  <= cfg_sel;
          chan_reg <= chan_of(link.chan_cfg, cfg_sel);
          if (!hold)  // start-up skipped
            state_reg <= recal ? ST_HOPWAIT : ST_INIT;
        end
        ST_SCAN: begin  // hold bit never read here
          if (!mode_select_bit) state_reg <= ST_SLEEP;
          else if (wake_s) state_reg <= ST_RUN_MODE_SELF_POLLING;
          else if (cnt_reg >= 16'(SCAN_CYC - 1)) begin
            cnt_reg <= '0;
            if (chan_reg < RMC_CH_3 &&
                chan_reg < chan_of(link.chan_cfg, cfg_reg))
              chan_reg <= chan_reg + 2'h1;
            else if (cfg_reg < last_cfg) begin
              cfg_reg  <= cfg_reg + 2'h1;
              chan_reg <= RMC_CH_1;
            end else begin
              state_reg <= ST_OFF;
              cfg_reg   <= RMC_CFG_A;
              chan_reg  <= RMC_CH_1;
            end
          end
        end
        ST_OFF: begin
          if (!mode_select_bit) state_reg <= ST_SLEEP;
          else if (cnt_reg >= {8'h0, off_len}) begin
            state_reg <= ST_SCAN;
            cnt_reg   <= '0;
          end
        end
        ST_RUN_MODE_SELF_POLLING: begin
          cnt_reg <= '0;
          if (!mode_select_bit) state_reg <= slrx ? ST_INIT : ST_SLEEP;
          else if (to_s || (eom_s && ret_s)) begin
            state_reg <= ST_SCAN;
            cfg_reg   <= RMC_CFG_A;
            chan_reg  <= RMC_CH_1;
          end
        end
        default: state_reg <= ST_SLEEP;
      endcase
    end
  end

  // ===========================================================
  // Frame handling in both run modes
  logic running;
  assign running = (state_reg == ST_RUN) || (state_reg == ST_RUN_MODE_SELF_POLLING);
  always_ff @(posedge clk) begin
    if (!rst_n || !running) begin
      pre_seen_reg <= 1'b0;
      in_frame_reg <= 1'b0;
    end else begin
      if (pre_s) pre_seen_reg <= 1'b1;
      if (sync_s && pre_seen_reg) in_frame_reg <= 1'b1;
      else if (eom_s) begin
        in_frame_reg <= 1'b0;
        pre_seen_reg <= 1'b0;
      end
    end
  end
  // Events are one-cycle pulses from flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link.frame_start <= 1'b0;
      link.id_match    <= 1'b0;
      link.msg_end     <= 1'b0;
      link.wake_event  <= 1'b0;
    end else begin
      link.frame_start <= running && sync_s && pre_seen_reg &&
                          !in_frame_reg;
      link.id_match    <= running && in_frame_reg && id_s;
      link.msg_end     <= running && in_frame_reg && eom_s;
      link.wake_event  <= (state_reg == ST_SCAN) && wake_s;
    end
  end
  // Payload only inside a frame; raw mode bypasses the FIFO
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fifo_wr   <= 1'b0;
      fifo_data <= '0;
    end else begin
      fifo_wr   <= running && in_frame_reg && bvld_s &&
                   !link.main_mode[MM_TRANSP];
      fifo_data <= byte2_reg;
    end
  end

  // ===========================================================
  // Outputs to RF section and host
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rf_power      <= 1'b0;
      osc_low_power <= 1'b1;
      vco_cal_start <= 1'b0;
      active_cfg    <= RMC_CFG_A;
      active_chan   <= RMC_CH_1;
      link.state    <= ST_SLEEP;
      link.acc_chan <= '0;
      link.acc_cfg  <= '0;
      link.mod_active <= 1'b0;
      link.transp   <= 1'b0;
    end else begin
      rf_power      <= (state_reg != ST_SLEEP) &&
                       (state_reg != ST_OFF);
      osc_low_power <= (state_reg == ST_SLEEP);
      vco_cal_start <= (state_reg == ST_HOLD) && !hold && recal;
      active_cfg    <= cfg_reg;
      active_chan   <= chan_reg;
      link.state    <= state_reg;
      if (state_reg == ST_SCAN && wake_s) begin
        link.acc_chan <= chan_reg;
        link.acc_cfg  <= cfg_reg;
      end
      // Polling scans with inverse of run-mode modulation
      link.mod_active <= (state_reg == ST_SCAN) ?
                         !link.main_mode[MM_MOD_TYPE] :
                         link.main_mode[MM_MOD_TYPE];
      link.transp   <= running && link.main_mode[MM_TRANSP];
    end
  end
endmodule // rmc_device
`default_nettype wire

// [core/rmc_host.sv]
// Host end: Wishbone register front that drives the receiver link
`timescale 1ns/1ns
`default_nettype none
module rmc_host
  import rmc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  rmc_if.host              link
);
  // ===========================================================
  // Control registers
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  logic wr_main, wr_chan, wr_poll, rd_evt;
  assign wr_main = req && wb_we_i && wb_adr_i == RMC_MAIN_MODE_ADDR &&
                   wb_sel_i[0];
  assign wr_chan = req && wb_we_i && wb_adr_i == RMC_CHAN_CFG_ADDR &&
                   wb_sel_i[0];
  assign wr_poll = req && wb_we_i && wb_adr_i == RMC_POLL_CFG_ADDR;
  assign rd_evt  = req && !wb_we_i && wb_adr_i == RMC_EVENT_ADDR;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link.main_mode <= '0;
      link.chan_cfg  <= '0;
      link.poll_cfg  <= '0;
    end else begin
      if (wr_main) link.main_mode <= wb_dat_i[7:0];
      // Software must only do this in sleep or hold
      if (wr_chan) link.chan_cfg <= wb_dat_i[7:0];
      if (wr_poll) begin
        if (wb_sel_i[0]) link.poll_cfg[7:0]  <= wb_dat_i[7:0];
        if (wb_sel_i[1]) link.poll_cfg[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // ===========================================================
  // Sticky events, cleared by reading; a new event wins
  logic [3:0] evt_reg;
  logic [3:0] evt_in;
  assign evt_in = {link.wake_event, link.msg_end, link.id_match,
                   link.frame_start};
  always_ff @(posedge clk) begin
    if (!rst_n) evt_reg <= '0;
    else        evt_reg <= (rd_evt ? 4'h0 : evt_reg) | evt_in;
  end

  // ===========================================================
  // Bus answer, one cycle after the request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= '0;
      if (req && !wb_we_i) begin
        unique case (wb_adr_i)
          RMC_MAIN_MODE_ADDR: wb_dat_o <= {24'h0, link.main_mode};
          RMC_CHAN_CFG_ADDR:  wb_dat_o <= {24'h0, link.chan_cfg};
          RMC_POLL_CFG_ADDR:  wb_dat_o <= {16'h0, link.poll_cfg};
          RMC_STATUS_ADDR:    wb_dat_o <= {21'h0, link.transp,
                                           link.mod_active, link.state};
          RMC_ACC_CHAN_ADDR:  wb_dat_o <= {28'h0, link.acc_cfg,
                                           link.acc_chan};
          RMC_EVENT_ADDR:     wb_dat_o <= {28'h0, evt_reg};
          default:            wb_dat_o <= '0;
        endcase
      end
    end
  end
endmodule // rmc_host
`default_nettype wire

// [test/rmc_assertions.sv]
// Checker: state sequencing properties on the receiver link
`timescale 1ns/1ns
`default_nettype none
module rmc_assertions
  import rmc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  main_mode,
  input wire logic [15:0] poll_cfg,
  input wire logic [8:0]  state,
  input wire logic        mod_active
);
  logic [8:0] prev_reg;
  logic [7:0] mode1_reg, mode_reg;
  int         len_reg;
  // ===========================================================
  // Run length of the state just left, mode as the device saw it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_reg <= ST_SLEEP;
      mode1_reg <= 8'h00;
      mode_reg <= 8'h00;
      len_reg  <= 1;
    end else begin
      prev_reg <= state;
      // State shows on the link one edge after the device decided
      mode1_reg <= main_mode;
      mode_reg <= mode1_reg;
      len_reg  <= (state == prev_reg) ? len_reg + 1 : 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence exit_from(logic [8:0] s);
    prev_reg == s && state != s;
  endsequence
  sequence enter_to(logic [8:0] s);
    prev_reg != s && state == s;
  endsequence
  // ===========================================================
  // Transitions
  hold_entry_a: assert property (
    enter_to(ST_HOLD) |-> prev_reg == ST_RUN && mode_reg[MM_HOLD])
    else $error("hold entered from wrong state");
  hold_exit_a: assert property (
    exit_from(ST_HOLD) |-> (state == ST_INIT && !mode_reg[MM_PLL_RECAL])
      || (state == ST_HOPWAIT && mode_reg[MM_PLL_RECAL]))
    else $error("hold left to wrong state");
  hop_time_a: assert property (
    exit_from(ST_HOPWAIT) |-> state == ST_INIT && len_reg == CHAN_HOP_CYC)
    else $error("channel hop wait wrong");
  startup_time_a: assert property (
    exit_from(ST_STARTUP) |-> state == ST_INIT && len_reg == STARTUP_CYC)
    else $error("start-up sequence wrong");
  sleep_exit_a: assert property (
    exit_from(ST_SLEEP) |-> state == ST_STARTUP)
    else $error("sleep left without start-up");
  init_exit_a: assert property (
    exit_from(ST_INIT) |-> len_reg == INIT_CYC
      && state == (mode_reg[MM_MODE_SEL] ? ST_SCAN : ST_RUN))
    else $error("init left wrongly");
  off_time_a: assert property (
    mode_reg[MM_MODE_SEL] ##0 exit_from(ST_OFF) |-> state == ST_SCAN
      && len_reg == poll_cfg[PC_OFF_LO +: 8] + 1)
    else $error("off time length wrong");
  run_mode_self_polling_entry_a: assert property (
    enter_to(ST_RUN_MODE_SELF_POLLING) |-> prev_reg == ST_SCAN)
    else $error("polling run entered wrongly");
  run_mode_self_polling_exit_a: assert property (
    exit_from(ST_RUN_MODE_SELF_POLLING) |-> state inside {ST_SCAN, ST_INIT, ST_SLEEP})
    else $error("polling run left wrongly");
  mod_switch_a: assert property (
    state == prev_reg && mode1_reg == main_mode &&
      state inside {ST_SCAN, ST_RUN_MODE_SELF_POLLING}
      |-> mod_active == ((state == ST_RUN_MODE_SELF_POLLING) ~^ mode1_reg[MM_MOD_TYPE]))
    else $error("modulation choice wrong");
endmodule // rmc_assertions
`default_nettype wire

// [test/test_receiver_mode_controller.sv]
// Testbench: host and device ends joined, run over Wishbone and RF pins
`timescale 1ns/1ns
`default_nettype none
module test_receiver_mode_controller
  import rmc_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n, cyc, stb, we, ack, eomr, rf_pw, osc_lp, vco_cal, fwr;
  logic [7:0]  adr, byte_in, fdat, last_b;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic [6:0]  pin;
  logic [1:0]  a_cfg, a_chan;
  logic [1:0]  exp_cfg [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1};
  logic [1:0]  exp_ch  [5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h2};
  int          n_errors = 0;
  int          num_checks = 0;
  int          n_wr = 0;
  int          n_cal = 0;

  always #20 clk = ~clk;
  rmc_if link ();
  rmc_host rmc_host_i (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .link(link));
  rmc_device rmc_device_i (
    .clk(clk), .rst_n(rst_n), .link(link), .rf_preamble(pin[0]),
    .rf_sync(pin[1]), .rf_id_ok(pin[2]), .rf_eom(pin[3]), .rf_wake(pin[4]),
    .rf_timeout(pin[5]), .eom_return(eomr), .rf_byte(byte_in),
    .rf_byte_vld(pin[6]), .rf_power(rf_pw), .osc_low_power(osc_lp),
    .vco_cal_start(vco_cal), .active_cfg(a_cfg), .active_chan(a_chan),
    .fifo_data(fdat), .fifo_wr(fwr));
  rmc_assertions rmc_assertions_i (
    .clk(clk), .rst_n(rst_n), .main_mode(link.main_mode),
    .poll_cfg(link.poll_cfg), .state(link.state),
    .mod_active(link.mod_active));
  // ===========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'h3;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("ack", 32'h1, {31'h0, ack});
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic wst(input logic [8:0] s, input int lim);
    int n;
    n = 0;
    while (link.state !== s && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("state", {23'h0, s}, {23'h0, link.state});
  endtask
  // Pins pass a two-flop synchroniser, so leave time to settle
  task automatic pulse(input int i);
    @(posedge clk);
    pin[i] <= 1'b1;
    @(posedge clk);
    pin[i] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    if (fwr === 1'b1) begin
      n_wr++;
      last_b = fdat;
    end
    if (vco_cal === 1'b1)
      n_cal++;
  end

  initial begin
    #(40 * 20000);
    n_errors++;
    stop_test();
  end
  // ===========================================================
  // Tests
  initial begin
    int n;
    {rst_n, cyc, stb, we, eomr} = 5'h0;
    {adr, byte_in, sel, wdat, pin} = 59'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rdc("status", RMC_STATUS_ADDR, 32'h001);
    rdc("accepted", RMC_ACC_CHAN_ADDR, 32'h0);
    chk("osc low", 32'h1, {31'h0, osc_lp});
    wb(1'b1, 8'h20, 32'hff);
    rdc("unmapped", 8'h20, 32'h0);
    wb(1'b1, RMC_CHAN_CFG_ADDR, 32'h0b);
    rdc("chan cfg", RMC_CHAN_CFG_ADDR, 32'h0b);
    $display("test reset done");
    wb(1'b1, RMC_MAIN_MODE_ADDR, 32'h02);
    wst(ST_STARTUP, 8);
    wst(ST_RUN, 600);
    pulse(1);
    rdc("sync alone", RMC_EVENT_ADDR, 32'h0);
    pulse(0);
    pulse(1);
    pulse(2);
    byte_in <= 8'ha5;
    pulse(6);
    pulse(3);
    rdc("frame events", RMC_EVENT_ADDR, 32'h7);
    rdc("events cleared", RMC_EVENT_ADDR, 32'h0);
    chk("fifo writes", 32'd1, n_wr);
    chk("fifo byte", 32'ha5, {24'h0, last_b});
    wb(1'b1, RMC_MAIN_MODE_ADDR, 32'h42);
    pulse(0);
    pulse(1);
    byte_in <= 8'h3c;
    pulse(6);
    chk("raw stream", 32'd1, n_wr);
    rdc("status raw", RMC_STATUS_ADDR, 32'h410);
    wb(1'b1, RMC_MAIN_MODE_ADDR, 32'h02);
    wb(1'b0, RMC_EVENT_ADDR, 32'h0);
    $display("test slave done");
    wb(1'b1, RMC_MAIN_MODE_ADDR, 32'h06);
    wst(ST_HOLD, 8);
    wb(1'b1, RMC_CHAN_CFG_ADDR, 32'h07);
    repeat (1000) @(posedge clk);
    wb(1'b1, RMC_MAIN_MODE_ADDR, 32'h02);
    wst(ST_INIT, 8);
    wst(ST_RUN, 12);
    wb(1'b1, RMC_MAIN_MODE_ADDR, 32'h0e);
    wst(ST_HOLD, 8);
    repeat (1000) @(posedge clk);
    wb(1'b1, RMC_MAIN_MODE_ADDR, 32'h0a);
    wst(ST_HOPWAIT, 8);
    wst(ST_RUN, 300);
    chk("vco cal", 32'd1, n_cal);
    wb(1'b1, RMC_MAIN_MODE_ADDR, 32'h00);
    wst(ST_SLEEP, 8);
    chk("rf power", 32'h0, {31'h0, rf_pw});
    $display("test hold done");
    wb(1'b1, RMC_CHAN_CFG_ADDR, 32'h0b);
    wb(1'b1, RMC_POLL_CFG_ADDR, 32'h0801);
    wb(1'b1, RMC_MAIN_MODE_ADDR, 32'h05);
    wst(ST_SCAN, 600);
    rdc("status scan", RMC_STATUS_ADDR, 32'h240);
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      chk("scan cfg", {30'h0, exp_cfg[i]}, {30'h0, a_cfg});
      chk("scan chan", {30'h0, exp_ch[i]}, {30'h0, a_chan});
      repeat (16) @(posedge clk);
    end
    chk("off time", {23'h0, ST_OFF}, {23'h0, link.state});
    n = 0;
    while (!(a_cfg === 2'h1 && a_chan === 2'h2) && n < 200) begin
      @(posedge clk);
      n++;
    end
    pulse(4);
    wst(ST_RUN_MODE_SELF_POLLING, 4);
    rdc("accepted", RMC_ACC_CHAN_ADDR, 32'h6);
    rdc("wake event", RMC_EVENT_ADDR, 32'h8);
    rdc("status run_mode_self_polling", RMC_STATUS_ADDR, 32'h100);
    pulse(5);
    wst(ST_SCAN, 4);
    chk("restart cfg", 32'h0, {30'h0, a_cfg});
    eomr <= 1'b1;
    pulse(4);
    wst(ST_RUN_MODE_SELF_POLLING, 4);
    pulse(3);
    wst(ST_SCAN, 4);
    pulse(4);
    wst(ST_RUN_MODE_SELF_POLLING, 4);
    wb(1'b1, RMC_MAIN_MODE_ADDR, 32'h00);
    wst(ST_SLEEP, 8);
    $display("test polling done");
    stop_test();
  end
endmodule // test_receiver_mode_controller
`default_nettype wire
